// >>> shared/led_seq_pkg.sv
// Constants shared by the boost LED enable and soft-start sequencer
`default_nettype none
package led_seq_pkg;
    // Clock
    localparam int CLK_MHZ           = 40;
    localparam int CLK_FREQ_HZ       = 40_000_000;
    localparam int COUNT_W           = 18;
    ////////////////////////////////////////////////////////////////////////
    // Times as printed, in their own units
    localparam int SHUTDOWN_TIME_US  = 2500;
    localparam int STEP_TIME_US      = 213;
    localparam int HALF_ILIM_TIME_US = 5000;
    localparam int DET_DELAY_TIME_US = 100;
    localparam int DET_LOW_TIME_US   = 260;
    localparam int DET_WIN_TIME_US   = 1000;
    localparam int ACK_TIME_US       = 512;
    localparam int SWITCH_FREQ_HZ    = 600_000;
    ////////////////////////////////////////////////////////////////////////
    // Cycle counts; all figures are whole cycles at 40 MHz
    localparam int SHUTDOWN_CYC      = SHUTDOWN_TIME_US * CLK_MHZ;
    localparam int STEP_CYC          = STEP_TIME_US * CLK_MHZ;
    localparam int HALF_ILIM_CYC     = HALF_ILIM_TIME_US * CLK_MHZ;
    localparam int DET_DELAY_CYC     = DET_DELAY_TIME_US * CLK_MHZ;
    localparam int DET_LOW_CYC       = DET_LOW_TIME_US * CLK_MHZ;
    localparam int DET_WIN_CYC       = DET_WIN_TIME_US * CLK_MHZ;
    localparam int ACK_CYC           = ACK_TIME_US * CLK_MHZ;
    // Count rounds down so the cycle never runs slower than 600 kHz
    localparam int SWITCH_CYC        = CLK_FREQ_HZ / SWITCH_FREQ_HZ;
    ////////////////////////////////////////////////////////////////////////
    // Soft start and brightness
    localparam int          REF_STEPS     = 32;
    localparam logic [5:0]  REF_FULL      = 6'h20;
    localparam logic [5:0]  REF_RESET     = 6'h00;
    localparam logic [4:0]  BRIGHT_RESET  = 5'h1F;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_SOFT  = 2'b01,
        ST_RUN   = 2'b10,
        ST_FAULT = 2'b11
    } seq_state_type;
endpackage
`default_nettype wire

// >>> shared/ctrl_mon_if.sv
// Control pin observations passed from the pin monitor to the sequencer
`timescale 1ns/100ps
`default_nettype none
interface ctrl_mon_if;
    logic                         lvl;
    logic                         rise;
    logic                         long_low;
    logic [led_seq_pkg::COUNT_W-1:0] low_cnt;
    modport mon (output lvl, output rise, output long_low, output low_cnt);
    modport seq (input lvl, input rise, input long_low, input low_cnt);
endinterface
`default_nettype wire

// >>> hw/ctrl_pin_monitor.sv
// Control pin synchroniser, edge finder and low-time counter
`timescale 1ns/100ps
`default_nettype none
module ctrl_pin_monitor #(
    parameter int SHUTDOWN_CYC = led_seq_pkg::SHUTDOWN_CYC
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  pin_i,
    ctrl_mon_if.mon    mon
);
    localparam int CW = led_seq_pkg::COUNT_W;

    logic                            meta_r;
    logic                            sync_r;
    logic                            prev_r;
    logic [led_seq_pkg::COUNT_W-1:0] low_cnt_r;
    logic [led_seq_pkg::COUNT_W-1:0] low_cnt_nxt;
    logic                            low_sat;

    ////////////////////////////////////////////////////////////////////////
    // Saturate so a very long low never wraps back under the limit
    assign low_sat     = &low_cnt_r;
    assign low_cnt_nxt = sync_r ? '0 : (low_sat ? low_cnt_r : low_cnt_r + 1'b1); // [R11]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r    <= 1'b0;
            sync_r    <= 1'b0;
            prev_r    <= 1'b0;
            low_cnt_r <= '0;
        end else begin
            meta_r    <= pin_i;                                     // [R11]
            sync_r    <= meta_r;
            prev_r    <= sync_r;
            low_cnt_r <= low_cnt_nxt;
        end
    end

    assign mon.lvl      = sync_r;
    assign mon.rise     = sync_r & ~prev_r;
    assign mon.long_low = low_cnt_r > CW'(SHUTDOWN_CYC);            // [R1]
    assign mon.low_cnt  = low_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    a_low_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        sync_r |=> low_cnt_r == '0 && !mon.long_low)
        else $error("low timer not restarted by high level");
endmodule
`default_nettype wire

// >>> hw/led_boost_enable_softstart_seq.sv
// Enable, soft-start, open-LED latch and acknowledge sequencer of the boost LED driver
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: A control pin held low longer than 2.5 ms puts the device in shutdown with switching off.
// R2: After enable the reference climbs from zero to target in 32 equal steps of 213 us each.
// R3: For the first 5 ms of start-up the switch current limit is half, then normal.
// R4: Each switching cycle, switch node over threshold with feedback under half level trips off.
// R5: After an open-LED trip the device stays off until the host toggles the control pin.
// R6: Acknowledge pulls the control line low, only for a command whose request bit was set.
// R7: The host provides the pull-up and releases the line while acknowledge may be driven.
// R8: Switching cycles run at a fixed 600 kHz while enabled and pace fault checks.
// R9: Every enable starts in pulse-width dimming; serial mode only if detected in that start.
// R10: The stored brightness step resets to full scale, step 31 of 32.
// R11: The control pin is synchronised and any high level restarts the shutdown timer.
module led_boost_enable_softstart_seq #(
    parameter int SHUTDOWN_CYC  = led_seq_pkg::SHUTDOWN_CYC,
    parameter int STEP_CYC      = led_seq_pkg::STEP_CYC,
    parameter int HALF_ILIM_CYC = led_seq_pkg::HALF_ILIM_CYC,
    parameter int DET_LOW_CYC   = led_seq_pkg::DET_LOW_CYC,
    parameter int DET_WIN_CYC   = led_seq_pkg::DET_WIN_CYC,
    parameter int ACK_CYC       = led_seq_pkg::ACK_CYC
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        CTRL_I,
    input  wire logic        OVP_CMP_I,
    input  wire logic        FEEDBACK_UV_CMP_I,
    input  wire logic        CMD_VALID_I,
    input  wire logic [4:0]  CMD_STEP_I,
    input  wire logic        CMD_ACK_REQ_I,
    output logic             CTRL_O,
    output logic             CTRL_OE_O,
    output logic             SWITCH_EN_O,
    output logic             CYCLE_START_O,
    output logic [5:0]       REF_LEVEL_O,
    output logic             HALF_ILIM_O,
    output logic             SHUTDOWN_O,
    output logic             FAULT_O,
    output logic             SERIAL_MODE_O,
    output logic [4:0]       BRIGHT_STEP_O
);
    localparam int CW = led_seq_pkg::COUNT_W;

    ctrl_mon_if                  ctrl_mon ();
    led_seq_pkg::seq_state_type  state_r;
    led_seq_pkg::seq_state_type  state_nxt;
    logic [CW-1:0] step_cnt_r;
    logic [CW-1:0] half_cnt_r;
    logic [CW-1:0] win_cnt_r;
    logic [CW-1:0] ack_cnt_r;
    logic [6:0]    cyc_cnt_r;
    logic [5:0]    ref_r;
    logic [4:0]    bright_r;
    logic          ovp_meta_r;
    logic          ovp_r;
    logic          uv_meta_r;
    logic          uv_r;
    logic          arm_r;
    logic          fall_ok_r;
    logic          serial_r;
    logic          half_r;
    logic          switch_r;
    logic          tick_r;
    logic          shut_r;
    logic          fault_r;
    logic          ack_r;

    ctrl_pin_monitor #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) u_mon (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .pin_i (CTRL_I),
        .mon   (ctrl_mon)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire active     = (state_r == led_seq_pkg::ST_SOFT) || (state_r == led_seq_pkg::ST_RUN);
    wire start      = ctrl_mon.lvl && ((state_r == led_seq_pkg::ST_OFF) ||
                      (state_r == led_seq_pkg::ST_FAULT && arm_r));      // [R5]
    wire trip       = active && tick_r && ovp_r && uv_r;                 // [R4]
    wire step_done  = step_cnt_r == CW'(STEP_CYC - 1);
    wire ramp_end   = (state_r == led_seq_pkg::ST_SOFT) && step_done &&
                      (ref_r == led_seq_pkg::REF_FULL - 6'h01);
    wire cyc_wrap   = cyc_cnt_r == 7'(led_seq_pkg::SWITCH_CYC - 1);
    wire in_window  = win_cnt_r < CW'(DET_WIN_CYC);
    wire det_hit    = active && fall_ok_r && !ctrl_mon.lvl && in_window &&
                      ctrl_mon.low_cnt == CW'(DET_LOW_CYC);              // [R9]
    wire ack_fire   = CMD_VALID_I && CMD_ACK_REQ_I && serial_r && !ack_r; // [R6]
    wire ack_end    = ack_r && ack_cnt_r == CW'(ACK_CYC - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            led_seq_pkg::ST_OFF: begin
                if (start) begin
                    state_nxt = led_seq_pkg::ST_SOFT;
                end
            end
            led_seq_pkg::ST_SOFT, led_seq_pkg::ST_RUN: begin
                if (trip) begin
                    state_nxt = led_seq_pkg::ST_FAULT;                   // [R4]
                end else if (ctrl_mon.long_low) begin
                    state_nxt = led_seq_pkg::ST_OFF;                     // [R1]
                end else if (ramp_end) begin
                    state_nxt = led_seq_pkg::ST_RUN;
                end
            end
            led_seq_pkg::ST_FAULT: begin
                if (start) begin
                    state_nxt = led_seq_pkg::ST_SOFT;                    // [R5]
                end
            end
            default: state_nxt = led_seq_pkg::ST_OFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchronisers and sequencer state
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ovp_meta_r <= 1'b0;
            ovp_r      <= 1'b0;
            uv_meta_r  <= 1'b0;
            uv_r       <= 1'b0;
            state_r    <= led_seq_pkg::ST_OFF;
            arm_r      <= 1'b0;
        end else begin
            ovp_meta_r <= OVP_CMP_I;
            ovp_r      <= ovp_meta_r;
            uv_meta_r  <= FEEDBACK_UV_CMP_I;
            uv_r       <= uv_meta_r;
            state_r    <= state_nxt;
            // Fault needs a low seen after the trip before a high counts
            arm_r      <= (state_r == led_seq_pkg::ST_FAULT) && (arm_r || !ctrl_mon.lvl); // [R5]
        end
    end

    // Switching cycle divider, idle while not enabled
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cyc_cnt_r <= 7'h00;
            tick_r    <= 1'b0;
        end else begin
            cyc_cnt_r <= (!active || cyc_wrap) ? 7'h00 : cyc_cnt_r + 7'h01; // [R8]
            tick_r    <= active && state_nxt != led_seq_pkg::ST_FAULT && cyc_wrap; // [R8]
        end
    end

    // Soft-start reference ramp and half current limit window
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ref_r      <= led_seq_pkg::REF_RESET;
            step_cnt_r <= '0;
            half_cnt_r <= '0;
            half_r     <= 1'b0;
        end else begin
            step_cnt_r <= (start || step_done) ? '0 : step_cnt_r + 1'b1;
            if (start || !active) begin
                ref_r <= led_seq_pkg::REF_RESET;
            end else if (state_r == led_seq_pkg::ST_SOFT && step_done) begin
                ref_r <= ref_r + 6'h01;                                  // [R2]
            end
            half_cnt_r <= start ? '0 : (half_r ? half_cnt_r + 1'b1 : half_cnt_r);
            half_r     <= start || (half_r && state_nxt != led_seq_pkg::ST_OFF &&
                          state_nxt != led_seq_pkg::ST_FAULT &&
                          half_cnt_r != CW'(HALF_ILIM_CYC - 1));        // [R3]
        end
    end

    // Dimming mode detection and stored brightness
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            win_cnt_r <= '0;
            fall_ok_r <= 1'b0;
            serial_r  <= 1'b0;
            bright_r  <= led_seq_pkg::BRIGHT_RESET;                      // [R10]
        end else begin
            win_cnt_r <= start ? '0 : (in_window ? win_cnt_r + 1'b1 : win_cnt_r);
            // The low phase only qualifies once the detection delay has gone by
            if (start) begin
                fall_ok_r <= 1'b0;
            end else if (ctrl_mon.lvl) begin
                fall_ok_r <= win_cnt_r >= CW'(led_seq_pkg::DET_DELAY_CYC - 1);
            end
            if (start) begin
                serial_r <= 1'b0;                                        // [R9]
            end else if (det_hit) begin
                serial_r <= 1'b1;                                        // [R9]
            end
            if (CMD_VALID_I && serial_r) begin
                bright_r <= CMD_STEP_I;
            end
        end
    end

    // Open-drain acknowledge, low only for a request with the bit set
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ack_r     <= 1'b0;
            ack_cnt_r <= '0;
        end else begin
            ack_r     <= ack_fire || (ack_r && !ack_end);                // [R6]
            ack_cnt_r <= ack_r ? ack_cnt_r + 1'b1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            switch_r <= 1'b0;
            shut_r   <= 1'b1;
            fault_r  <= 1'b0;
        end else begin
            switch_r <= state_nxt == led_seq_pkg::ST_SOFT || state_nxt == led_seq_pkg::ST_RUN; // [R1]
            shut_r   <= state_nxt == led_seq_pkg::ST_OFF || state_nxt == led_seq_pkg::ST_FAULT;
            fault_r  <= state_nxt == led_seq_pkg::ST_FAULT;
        end
    end

    assign CTRL_O        = 1'b0 & ack_r;
    assign CTRL_OE_O     = ack_r;
    assign SWITCH_EN_O   = switch_r;
    assign CYCLE_START_O = tick_r;
    assign REF_LEVEL_O   = ref_r;
    assign HALF_ILIM_O   = half_r;
    assign SHUTDOWN_O    = shut_r;
    assign FAULT_O       = fault_r;
    assign SERIAL_MODE_O = serial_r;
    assign BRIGHT_STEP_O = bright_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_long_low_off: assert property ( // [R1]
        active && ctrl_mon.long_low && !trip |=> state_r == led_seq_pkg::ST_OFF ##0 !SWITCH_EN_O)
        else $error("long low did not shut down");
    a_step_advance: assert property ( // [R2]
        state_r == led_seq_pkg::ST_SOFT && state_nxt == led_seq_pkg::ST_SOFT && step_done
        |=> ref_r == $past(ref_r) + 6'h01)
        else $error("reference step missed");
    a_run_full_ref: assert property ( // [R2]
        state_r == led_seq_pkg::ST_RUN |-> ref_r == led_seq_pkg::REF_FULL)
        else $error("run without full reference");
    a_half_limit_start: assert property ( // [R3]
        start |=> HALF_ILIM_O && half_cnt_r == '0)
        else $error("half limit not applied at start");
    a_open_led_trip: assert property ( // [R4]
        trip |=> FAULT_O && !SWITCH_EN_O && state_r == led_seq_pkg::ST_FAULT)
        else $error("open LED trip ignored");
    a_fault_latched: assert property ( // [R5]
        state_r == led_seq_pkg::ST_FAULT && !arm_r |=> state_r == led_seq_pkg::ST_FAULT)
        else $error("fault released without toggle");
    a_ack_cause: assert property ( // [R6]
        $rose(CTRL_OE_O) |-> $past(CMD_VALID_I && CMD_ACK_REQ_I) && !CTRL_O)
        else $error("acknowledge without request");
    a_cycle_gap: assert property ( // [R8]
        CYCLE_START_O |=> !CYCLE_START_O [*8])
        else $error("switching cycles too close");
    a_mode_default: assert property ( // [R9]
        start |=> !SERIAL_MODE_O)
        else $error("enable did not restore pulse-width dimming");

    c_soft_to_run: cover property (state_r == led_seq_pkg::ST_SOFT ##1 state_r == led_seq_pkg::ST_RUN);
    c_fault_trip:  cover property (trip);
    c_serial_mode: cover property ($rose(SERIAL_MODE_O));
    c_ack_pulse:   cover property ($fell(CTRL_OE_O));
    c_enable_edge: cover property (ctrl_mon.rise && state_r == led_seq_pkg::ST_OFF);
endmodule
`default_nettype wire

// >>> tb/ctrl_host_model.sv
// Host side of the control line: open-drain drive plus the line pull-up
`timescale 1ns/100ps
`default_nettype none
module ctrl_host_model (
    input  wire logic  host_low_i,
    input  wire logic  dev_oe_i,
    input  wire logic  dev_val_i,
    output logic       line_o
);
    // Device can only pull low; it never drives the line high
    wire logic dev_pull = dev_oe_i & ~dev_val_i;
    // Host pulls low or releases; a released line rises to the pull-up level
    // Restart after a trip needs the host to toggle the line low then high
    assign line_o = ~(host_low_i | dev_pull);
endmodule
`default_nettype wire

// >>> tb/led_boost_enable_softstart_seq_test.sv
// Self-checking testbench of the enable and soft-start sequencer
`timescale 1ns/100ps
`default_nettype none
module led_boost_enable_softstart_seq_test;
    localparam int SHUT = 200, STEP = 20, HALF = 300, DLOW = 50, DWIN = 5000, ACK = 30;
    localparam int LIMIT = 20000;
    typedef struct { string name; int sel; logic [7:0] exp; } note_type;
    logic        clk, rst, host_low, ovp, uv, cvalid, cack, line;
    logic [4:0]  cstep, last_step;
    logic        ctrl_val, ctrl_oe, sw_en, cyc, half, shut, fault, serial;
    logic [5:0]  ref_lvl;
    logic [4:0]  bright;
    logic [7:0]  gap_r;
    logic [31:0] rs = 32'h00017C51;
    note_type    q[$];
    int          failures = 0, compares = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    led_boost_enable_softstart_seq #(.SHUTDOWN_CYC(SHUT), .STEP_CYC(STEP),
        .HALF_ILIM_CYC(HALF), .DET_LOW_CYC(DLOW), .DET_WIN_CYC(DWIN), .ACK_CYC(ACK)
    ) led_boost_enable_softstart_seq_inst (
        .CLK_SYS_I(clk), .RST_I(rst), .CTRL_I(line), .OVP_CMP_I(ovp), .FEEDBACK_UV_CMP_I(uv),
        .CMD_VALID_I(cvalid), .CMD_STEP_I(cstep), .CMD_ACK_REQ_I(cack),
        .CTRL_O(ctrl_val), .CTRL_OE_O(ctrl_oe), .SWITCH_EN_O(sw_en), .CYCLE_START_O(cyc),
        .REF_LEVEL_O(ref_lvl), .HALF_ILIM_O(half), .SHUTDOWN_O(shut), .FAULT_O(fault),
        .SERIAL_MODE_O(serial), .BRIGHT_STEP_O(bright)
    );
    ctrl_host_model ctrl_host_model_inst (
        .host_low_i(host_low), .dev_oe_i(ctrl_oe), .dev_val_i(ctrl_val), .line_o(line)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [7:0] pick(input int sel);
        case (sel)
            0: return {7'h00, sw_en};
            1: return {7'h00, shut};
            2: return {7'h00, fault};
            3: return {2'h0, ref_lvl};
            4: return {7'h00, half};
            5: return {7'h00, serial};
            6: return {7'h00, ctrl_oe};
            7: return {3'h0, bright};
            8: return {7'h00, line};
            default: return gap_r;
        endcase
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic note(input string name, input int sel, input logic [7:0] exp);
        q.push_back('{name, sel, exp});
    endtask
    // Results are taken off the queue mid-cycle, once the edge's updates have landed
    always @(negedge clk) begin : watch
        note_type n;
        while (q.size() > 0) begin
            n = q.pop_front();
            check(n.name, pick(n.sel), n.exp);
        end
    end
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            failures++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Host release; enable seen two edges after the synchroniser takes it
    task automatic enable();
        host_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic send(input logic [4:0] s, input logic a);
        cvalid <= 1'b1;
        cstep  <= s;
        cack   <= a;
        @(posedge clk);
        cvalid <= 1'b0;
        cack   <= 1'b0;
    endtask
    task automatic measure_gap();
        int c;
        c = 0;
        while (cyc !== 1'b1 && c < 200) begin
            @(posedge clk); #1; c++;
        end
        c = 0;
        do begin
            @(posedge clk); #1; c++;
        end while (cyc !== 1'b1 && c < 200);
        gap_r = c[7:0];
        @(posedge clk);
        note("cycle_gap", 9, 8'(led_seq_pkg::SWITCH_CYC));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin : main
        int pts[5] = '{1, 5, 16, 31, 32};
        int t;
        logic [4:0] s;
        rst = 1'b1; host_low = 1'b1; ovp = 1'b0; uv = 1'b0;
        cvalid = 1'b0; cack = 1'b0; cstep = 5'h00; gap_r = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        note("shutdown", 1, 8'h01);
        note("bright", 7, 8'h1F);
        note("switch", 0, 8'h00);
        $display("Test reset done");
        enable();
        note("switch", 0, 8'h01);
        note("ref", 3, 8'h00);
        t = 0;
        foreach (pts[i]) begin
            repeat (pts[i] * STEP + STEP / 2 - t) @(posedge clk);
            t = pts[i] * STEP + STEP / 2;
            note("ref", 3, pts[i][7:0]);
            note("half", 4, (t < HALF - 1) ? 8'h01 : 8'h00);
        end
        measure_gap();
        $display("Test soft start done");
        // Detection low lands between the detection delay and the window end
        repeat (3400) @(posedge clk);
        host_low <= 1'b1;
        repeat (60) @(posedge clk);
        host_low <= 1'b0;
        repeat (4) @(posedge clk);
        note("serial", 5, 8'h01);
        note("switch", 0, 8'h01);
        for (int a = 1; a >= 0; a--) begin
            s = 5'(rnd());
            last_step = s;
            send(s, a[0]);
            note("ack", 6, a[7:0]);
            note("bright", 7, {3'h0, s});
            repeat (20) @(posedge clk);
            note("line", 8, {7'h00, ~a[0]});
            repeat (20) @(posedge clk);
            note("ack", 6, 8'h00);
        end
        $display("Test serial commands done");
        host_low <= 1'b1;
        repeat (150) @(posedge clk);
        host_low <= 1'b0;
        repeat (5) @(posedge clk);
        note("switch", 0, 8'h01);
        host_low <= 1'b1;
        // Both lows together exceed the limit; only the restart keeps switching on
        repeat (100) @(posedge clk);
        note("switch", 0, 8'h01);
        repeat (140) @(posedge clk);
        note("switch", 0, 8'h00);
        note("shutdown", 1, 8'h01);
        enable();
        note("serial", 5, 8'h00);
        note("bright", 7, {3'h0, last_step});
        send(5'(rnd()), 1'b1);
        note("ack", 6, 8'h00);
        note("bright", 7, {3'h0, last_step});
        $display("Test shutdown done");
        ovp <= 1'b1;
        repeat (150) @(posedge clk);
        note("fault", 2, 8'h00);
        uv <= 1'b1;
        repeat (75) @(posedge clk);
        note("fault", 2, 8'h01);
        note("switch", 0, 8'h00);
        note("shutdown", 1, 8'h01);
        ovp <= 1'b0;
        uv  <= 1'b0;
        host_low <= 1'b1;
        repeat (240) @(posedge clk);
        note("fault", 2, 8'h01);
        enable();
        note("fault", 2, 8'h00);
        note("switch", 0, 8'h01);
        $display("Test open fault done");
        repeat (5) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
